// ==== inc/ampc_pkg.sv ====
// =====================================================================
// Shared constants and carriers for the amplifier mode/power control
// =====================================================================
package ampc_pkg;

  // =================================================================
  // Clock and turn-on timing
  // =================================================================
  localparam longint unsigned CLK_HZ      = 64'd125_000_000;
  localparam longint unsigned TURN_ON_MS  = 64'd600;
  // Whole cycles of the nominal turn-on phase
  localparam longint unsigned TURN_ON_CYC = (TURN_ON_MS * CLK_HZ) / 64'd1000;

  // =================================================================
  // Register map (byte addresses, one aligned word each)
  // =================================================================
  localparam int          ADR_W       = 8;
  localparam logic [7:0]  MODE_OFS    = 8'h00;
  localparam logic [7:0]  STATUS_OFS  = 8'h04;

  // Mode register fields
  localparam int          MODE_RUN_BIT   = 0;
  localparam int          MODE_UNMUTE_BIT = 1;
  localparam logic [1:0]  MODE_RST       = 2'h0;

  // Status register fields
  localparam int ST_SHUTDOWN_BIT = 0;
  localparam int ST_MUTE_BIT     = 1;
  localparam int ST_TURN_ON_BIT  = 2;
  localparam int ST_SPEAKER_BIT  = 3;
  localparam int ST_SUPPLY_BIT   = 4;
  localparam int ST_HPSENSE_BIT  = 5;
  localparam int ST_OUTMUTE_BIT  = 6;

  // =================================================================
  // Serial control byte
  // =================================================================
  localparam logic [3:0] SPI_BITS      = 4'h8;
  localparam int         SPI_SEL_BIT   = 7;
  localparam int         SPI_FIX_BIT   = 5;

  // =================================================================
  // Carriers
  // =================================================================
  typedef struct packed {
    logic unmute;
    logic run;
  } ampc_mode_t;

  typedef struct packed {
    logic switching_en;
    logic low_power;
    logic input_connect;
    logic bias_en;
    logic hp_amp_en;
    logic speaker_en;
    logic driver_en;
    logic fets_off;
    logic mute;
  } ampc_drive_t;

  localparam ampc_drive_t DRIVE_RST = '{
    switching_en:  1'b0,
    low_power:     1'b1,
    input_connect: 1'b0,
    bias_en:       1'b0,
    hp_amp_en:     1'b0,
    speaker_en:    1'b0,
    driver_en:     1'b0,
    fets_off:      1'b1,
    mute:          1'b1
  };

endpackage

// ==== src/ampc_top.sv ====
`timescale 1ns/100ps
// Contract
// - Mode bit 0 written 0 enters shutdown, written 1 returns to operation.
// - In shutdown switching stops and the amplifier sits at lowest current.
// - After power-on the device is in shutdown before any host write.
// - Mode bit 1 written 0 mutes speaker and headphone, written 1 unmutes.
// - Mute disconnects the audio input internally while bias stays applied.
// - After power-on speaker and headphone outputs are muted.
// - The headphone amplifier stays enabled, also while the speaker stage runs.
// - Headphone sense low keeps the speaker stage enabled.
// - Headphone sense high disables the speaker stage.
// - Supply below 8V forces all power transistors off and drivers disabled.
// - After power-up or leaving shutdown a turn-on phase of 600ms runs.
// - During the turn-on phase outputs stay muted whatever the mute bit says.
// - Serial enable held past eight clocks latches only the first eight bits.
module ampc_top #(
  parameter int unsigned TURN_ON_CYCLES = int'(ampc_pkg::TURN_ON_CYC)
) (
  input  wire logic                     mclk_i,
  input  wire logic                     reset_i,
  input  wire logic                     wb_cyc_i,
  input  wire logic                     wb_stb_i,
  input  wire logic                     wb_we_i,
  input  wire logic [ampc_pkg::ADR_W-1:0] wb_adr_i,
  input  wire logic [3:0]               wb_sel_i,
  input  wire logic [31:0]              wb_dat_i,
  output logic      [31:0]              wb_dat_o,
  output logic                          wb_ack_o,
  input  wire logic                     spi_clk_i,
  input  wire logic                     spi_data_i,
  input  wire logic                     spi_enable_n_i,
  input  wire logic                     headphone_sense_input_i,
  input  wire logic                     supply_low_i,
  output ampc_pkg::ampc_drive_t         drive_o
);
  import ampc_pkg::*;

  localparam int CNT_W = $clog2(TURN_ON_CYCLES + 1);
  localparam logic [CNT_W-1:0] CNT_LOAD = CNT_W'(TURN_ON_CYCLES - 1);

  // =================================================================
  // Declarations
  // =================================================================
  ampc_mode_t        mode_ff;
  ampc_mode_t        nxt_mode;
  logic              turn_on_ff;
  logic [CNT_W-1:0]  turn_cnt_ff;
  logic              spi_clk_prev_ff;
  logic [3:0]        spi_cnt_ff;
  logic [6:0]        spi_shift_ff;
  logic              spi_rise;
  logic              spi_apply;
  logic [7:0]        spi_byte;
  logic              wb_req;
  logic              wb_wr_mode;
  ampc_drive_t       nxt_drive;
  logic [31:0]       nxt_rdata;
  logic              leave_shutdown;

  assign wb_req         = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wb_wr_mode     = wb_req && wb_we_i && wb_sel_i[0] && (wb_adr_i == MODE_OFS);
  assign leave_shutdown = !mode_ff.run && nxt_mode.run;

  // =================================================================
  // Serial control port
  // =================================================================
  assign spi_rise  = spi_clk_i && !spi_clk_prev_ff;
  assign spi_byte  = {spi_shift_ff[6:0], spi_data_i};
  assign spi_apply = !spi_enable_n_i && spi_rise && (spi_cnt_ff == SPI_BITS - 4'h1);

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      spi_clk_prev_ff <= 1'b0;
    end else begin
      spi_clk_prev_ff <= spi_clk_i;
    end
  end

  // Enable going high before the eighth edge drops the partial byte
  always_ff @(posedge mclk_i) begin
    if (reset_i || spi_enable_n_i) begin
      spi_cnt_ff   <= 4'h0;
      spi_shift_ff <= 7'h00;
    end else if (spi_rise && (spi_cnt_ff != SPI_BITS)) begin
      spi_cnt_ff   <= spi_cnt_ff + 4'h1;
      spi_shift_ff <= spi_byte[6:0];
    end
  end

  // =================================================================
  // Mode register
  // =================================================================
  // Bus write is taken after a same-cycle serial byte, so the bus wins
  always_comb begin
    nxt_mode = mode_ff;
    if (spi_apply && !spi_byte[SPI_SEL_BIT] && !spi_byte[SPI_FIX_BIT]) begin
      nxt_mode.run    = spi_byte[MODE_RUN_BIT];
      nxt_mode.unmute = spi_byte[MODE_UNMUTE_BIT];
    end
    if (wb_wr_mode) begin
      nxt_mode.run    = wb_dat_i[MODE_RUN_BIT];
      nxt_mode.unmute = wb_dat_i[MODE_UNMUTE_BIT];
    end
  end

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      mode_ff <= ampc_mode_t'(MODE_RST);
    end else begin
      mode_ff <= nxt_mode;
    end
  end

  // =================================================================
  // Turn-on timer
  // =================================================================
  // Power-up lands in shutdown, so the first exit also starts the timer
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      turn_on_ff  <= 1'b0;
      turn_cnt_ff <= '0;
    end else if (!nxt_mode.run) begin
      turn_on_ff  <= 1'b0;
      turn_cnt_ff <= '0;
    end else if (leave_shutdown) begin
      turn_on_ff  <= 1'b1;
      turn_cnt_ff <= CNT_LOAD;
    end else if (turn_on_ff) begin
      if (turn_cnt_ff == '0) begin
        turn_on_ff <= 1'b0;
      end else begin
        turn_cnt_ff <= turn_cnt_ff - CNT_W'(1);
      end
    end
  end

  // =================================================================
  // Output controls
  // =================================================================
  always_comb begin
    nxt_drive = DRIVE_RST;
    nxt_drive.switching_en  = mode_ff.run && !supply_low_i;
    nxt_drive.low_power     = !mode_ff.run;
    nxt_drive.mute          = !mode_ff.run || !mode_ff.unmute || turn_on_ff;
    nxt_drive.input_connect = !nxt_drive.mute;
    nxt_drive.bias_en       = mode_ff.run;
    nxt_drive.hp_amp_en     = mode_ff.run;
    nxt_drive.speaker_en    = mode_ff.run && !headphone_sense_input_i;
    nxt_drive.driver_en     = mode_ff.run && !supply_low_i;
    nxt_drive.fets_off      = supply_low_i || !mode_ff.run;
  end

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      drive_o <= DRIVE_RST;
    end else begin
      drive_o <= nxt_drive;
    end
  end

  // =================================================================
  // Wishbone slave
  // =================================================================
  // Unmapped addresses still ack and read as zero, so a stray access never hangs
  always_comb begin
    nxt_rdata = 32'h0000_0000;
    case (wb_adr_i)
      MODE_OFS: begin
        nxt_rdata[MODE_RUN_BIT]    = mode_ff.run;
        nxt_rdata[MODE_UNMUTE_BIT] = mode_ff.unmute;
      end
      STATUS_OFS: begin
        nxt_rdata[ST_SHUTDOWN_BIT] = !mode_ff.run;
        nxt_rdata[ST_MUTE_BIT]     = !mode_ff.unmute;
        nxt_rdata[ST_TURN_ON_BIT]  = turn_on_ff;
        nxt_rdata[ST_SPEAKER_BIT]  = drive_o.speaker_en;
        nxt_rdata[ST_SUPPLY_BIT]   = supply_low_i;
        nxt_rdata[ST_HPSENSE_BIT]  = headphone_sense_input_i;
        nxt_rdata[ST_OUTMUTE_BIT]  = drive_o.mute;
      end
      default: begin
        nxt_rdata = 32'h0000_0000;
      end
    endcase
  end

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= wb_req;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (wb_req && !wb_we_i) begin
      wb_dat_o <= nxt_rdata;
    end
  end

  // =================================================================
  // Checks
  // =================================================================
  // Busy length kept in a counter, since a long repetition would be slow to check
  logic [CNT_W:0] busy_len_ff;

  always_ff @(posedge mclk_i) begin
    if (reset_i || !turn_on_ff) begin
      busy_len_ff <= '0;
    end else begin
      busy_len_ff <= busy_len_ff + (CNT_W+1)'(1);
    end
  end

  default clocking chk_cb @(posedge mclk_i);
  endclocking
  default disable iff (reset_i);

  shutdown_entry_a: assert property (
    wb_wr_mode && !wb_dat_i[MODE_RUN_BIT] |=> !mode_ff.run ##1 !drive_o.switching_en)
    else $error("shutdown write did not stop switching");

  shutdown_quiet_a: assert property (
    !mode_ff.run |=> drive_o.low_power && !drive_o.switching_en && !drive_o.driver_en)
    else $error("shutdown not at lowest current");

  poweron_state_a: assert property (
    $past(reset_i) |-> !mode_ff.run && !turn_on_ff && drive_o.low_power)
    else $error("not in shutdown after reset");

  mute_write_a: assert property (
    wb_wr_mode && !wb_dat_i[MODE_UNMUTE_BIT] |=> !mode_ff.unmute ##1 drive_o.mute)
    else $error("mute write did not mute outputs");

  mute_input_cut_a: assert property (
    drive_o.mute |-> !drive_o.input_connect && (drive_o.bias_en == !drive_o.low_power))
    else $error("muted output still connected or unbiased");

  poweron_mute_a: assert property (
    $past(reset_i) |-> drive_o.mute && !mode_ff.unmute)
    else $error("outputs not muted after reset");

  hp_path_on_a: assert property (
    mode_ff.run |=> drive_o.hp_amp_en)
    else $error("headphone path dropped while running");

  speaker_sense_a: assert property (
    mode_ff.run && !headphone_sense_input_i |=> drive_o.speaker_en)
    else $error("speaker disabled with sense low");

  speaker_off_a: assert property (
    headphone_sense_input_i |=> !drive_o.speaker_en)
    else $error("speaker enabled with sense high");

  undervolt_off_a: assert property (
    supply_low_i |=> drive_o.fets_off && !drive_o.driver_en && !drive_o.switching_en)
    else $error("drivers active during undervoltage");

  turn_on_len_a: assert property (
    $fell(turn_on_ff) && mode_ff.run |-> busy_len_ff == (CNT_W+1)'(TURN_ON_CYCLES))
    else $error("turn-on phase length wrong");

  turn_on_mute_a: assert property (
    turn_on_ff |=> drive_o.mute && !drive_o.input_connect)
    else $error("outputs unmuted during turn-on");

  spi_hold_a: assert property (
    !spi_enable_n_i && (spi_cnt_ff == SPI_BITS) |-> !spi_apply ##1
      (spi_enable_n_i || spi_cnt_ff == SPI_BITS))
    else $error("serial byte applied past eighth edge");

  cancel_timer_a: assert property (
    $fell(mode_ff.run) |-> !turn_on_ff ##1 (!mode_ff.run || turn_cnt_ff == CNT_LOAD))
    else $error("turn-on timer not cancelled by shutdown");

  spi_mode_load_a: assert property (
    spi_apply && !spi_byte[SPI_SEL_BIT] && !spi_byte[SPI_FIX_BIT] && !wb_wr_mode |=>
      mode_ff.run == $past(spi_byte[MODE_RUN_BIT]) &&
      mode_ff.unmute == $past(spi_byte[MODE_UNMUTE_BIT]))
    else $error("serial mode byte not applied");

  bus_mode_load_a: assert property (
    wb_wr_mode |=> mode_ff.run == $past(wb_dat_i[MODE_RUN_BIT]) &&
      mode_ff.unmute == $past(wb_dat_i[MODE_UNMUTE_BIT]))
    else $error("bus mode write not applied");

  spi_count_cap_a: assert property (
    spi_cnt_ff <= SPI_BITS)
    else $error("serial bit count past eight");

  turn_on_start_a: assert property (
    leave_shutdown |=> turn_on_ff && (turn_cnt_ff == CNT_LOAD))
    else $error("turn-on phase not started in full");

  turn_on_cap_a: assert property (
    busy_len_ff <= (CNT_W+1)'(TURN_ON_CYCLES))
    else $error("turn-on phase too long");

  speaker_hp_a: assert property (
    drive_o.speaker_en |-> drive_o.hp_amp_en)
    else $error("headphone path off while speaker runs");

  mute_release_a: assert property (
    mode_ff.run && mode_ff.unmute && !turn_on_ff |=> !drive_o.mute && drive_o.input_connect)
    else $error("outputs still muted after unmute");

  run_drive_a: assert property (
    mode_ff.run && !supply_low_i |=> drive_o.switching_en && drive_o.driver_en && !drive_o.fets_off)
    else $error("drivers not running in operation");

  shutdown_stage_a: assert property (
    !mode_ff.run |=> !drive_o.speaker_en && !drive_o.bias_en && !drive_o.input_connect)
    else $error("stages still on in shutdown");

  turn_on_done_c: cover property (
    leave_shutdown ##1 turn_on_ff ##[1:1000] ($fell(turn_on_ff) && mode_ff.run));

  spi_apply_c: cover property (spi_apply && !spi_byte[SPI_SEL_BIT]);

  hp_plug_c: cover property (
    mode_ff.run && drive_o.speaker_en ##1 headphone_sense_input_i ##1 !drive_o.speaker_en);

  uv_run_c: cover property (mode_ff.run && !turn_on_ff && supply_low_i);

  spi_surplus_c: cover property (!spi_enable_n_i && spi_rise && (spi_cnt_ff == SPI_BITS));

endmodule

// ==== tb/ampc_spi_host.sv ====
`timescale 1ns/100ps
// =====================================================================
// Host side of the serial control port
// =====================================================================
module ampc_spi_host (
  input  wire logic mclk_i,
  output logic      spi_clk_o,
  output logic      spi_data_o,
  output logic      spi_enable_n_o
);
  initial begin
    spi_clk_o      = 1'b0;
    spi_data_o     = 1'b0;
    spi_enable_n_o = 1'b1;
  end

  // Clock stands low between frames; four mclk per phase keeps it slow
  task automatic send(input logic [7:0] byte_v, input int pulses);
    spi_enable_n_o <= 1'b0;
    for (int i = 0; i < pulses; i++) begin
      spi_data_o <= (i < 8) ? byte_v[7-i] : 1'b1;
      repeat (4) @(posedge mclk_i);
      spi_clk_o <= 1'b1;
      repeat (4) @(posedge mclk_i);
      spi_clk_o <= 1'b0;
    end
    repeat (4) @(posedge mclk_i);
    spi_enable_n_o <= 1'b1;
    // Released data flips so a stale bit never looks driven
    spi_data_o <= ~spi_data_o;
    repeat (4) @(posedge mclk_i);
  endtask
endmodule

// ==== tb/tb_amp_mode_power_control.sv ====
`timescale 1ns/100ps
module tb_amp_mode_power_control;
  import ampc_pkg::*;
  localparam int T = 20;
  logic mclk_i = 1'b0, reset_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [3:0]  sel = 4'h0;
  logic [31:0] dat = 32'h0, rd_q;
  logic [3:0]  wsel = 4'h1;
  logic [31:0] wb_dat_o;
  logic        wb_ack_o, hp = 1'b0, low = 1'b1, sclk, sdat, sen_n;
  ampc_drive_t drive_o;
  int          failures = 0, n_compared = 0, cycles = 0;
  logic [7:0]  sbyte [4] = '{8'h01, 8'h83, 8'h23, 8'h03};
  logic [31:0] smode [4] = '{32'h1, 32'h1, 32'h1, 32'h3};
  logic [1:0]  m;

  ampc_top #(.TURN_ON_CYCLES(T)) dut (
    .mclk_i(mclk_i), .reset_i(reset_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .spi_clk_i(sclk), .spi_data_i(sdat), .spi_enable_n_i(sen_n),
    .headphone_sense_input_i(hp), .supply_low_i(low), .drive_o(drive_o));
  ampc_spi_host host (.mclk_i(mclk_i), .spi_clk_o(sclk), .spi_data_o(sdat),
    .spi_enable_n_o(sen_n));

  initial begin
    forever #4 mclk_i = ~mclk_i;
  end

  // =====================================================================
  // Checking and closing
  // =====================================================================
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH t=%0t seen %h exp %h", $time, seen, exp);
    end
  endtask

  task automatic wrap_up;
    if (failures == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  always @(posedge mclk_i) begin
    cycles <= cycles + 1;
    if (cycles == 8000) begin
      failures++;
      wrap_up();
    end
  end

  // =====================================================================
  // Bus cycles
  // =====================================================================
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    cyc <= 1'b1;
    stb <= 1'b1;
    we  <= w;
    adr <= a;
    dat <= d;
    sel <= wsel;
    do begin
      @(posedge mclk_i);
    end while (wb_ack_o !== 1'b1);
    rd_q = wb_dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge mclk_i);
  endtask

  // Expected controls once any turn-on phase is over
  function automatic ampc_drive_t exp_drive(input logic run, input logic un);
    ampc_drive_t e;
    e.switching_en  = run & !low;
    e.low_power     = !run;
    e.input_connect = run & un;
    e.bias_en       = run;
    e.hp_amp_en     = run;
    e.speaker_en    = run & !hp;
    e.driver_en     = run & !low;
    e.fets_off      = !run | low;
    e.mute          = !run | !un;
    return e;
  endfunction

  task automatic check_drive(input logic run, input logic un);
    check({23'h0, drive_o}, {23'h0, exp_drive(run, un)});
  endtask

  task automatic turn_on_len;
    int n;
    n = 0;
    while (drive_o.mute === 1'b1 && n < 200) begin
      @(posedge mclk_i);
      n++;
    end
    check(32'(n >= T - 3 && n <= T + 1), 32'h1);
  endtask

  // =====================================================================
  // Main sequence
  // =====================================================================
  initial begin
    void'($urandom(32'h8f1eac78));
    repeat (6) @(posedge mclk_i);
    reset_i <= 1'b0;
    @(posedge mclk_i);
    check({23'h0, drive_o}, {23'h0, DRIVE_RST});
    wb(1'b0, MODE_OFS, 32'h0);
    check(rd_q, 32'h0);
    wb(1'b0, STATUS_OFS, 32'h0);
    check(rd_q, (32'h1 << ST_SHUTDOWN_BIT) | (32'h1 << ST_MUTE_BIT) |
      (32'h1 << ST_SUPPLY_BIT) | (32'h1 << ST_OUTMUTE_BIT));
    wb(1'b0, 8'h10, 32'h0);
    check(rd_q, 32'h0);
    // main supply present before the first write
    low <= 1'b0;
    @(posedge mclk_i);
    wb(1'b1, MODE_OFS, 32'h3);
    turn_on_len();
    check_drive(1'b1, 1'b1);
    wb(1'b1, MODE_OFS, 32'h0);
    wb(1'b1, MODE_OFS, 32'h3);
    repeat (T / 2) @(posedge mclk_i);
    wb(1'b1, MODE_OFS, 32'h2);
    repeat (2) @(posedge mclk_i);
    check_drive(1'b0, 1'b1);
    wb(1'b0, STATUS_OFS, 32'h0);
    check({31'h0, rd_q[ST_TURN_ON_BIT]}, 32'h0);
    wb(1'b1, MODE_OFS, 32'h3);
    turn_on_len();
    for (int i = 0; i < 12; i++) begin
      m = 2'($urandom);
      hp <= 1'($urandom);
      low <= 1'($urandom);
      wb(1'b1, MODE_OFS, {30'h0, m});
      repeat (T + 6) @(posedge mclk_i);
      check_drive(m[0], m[1]);
    end
    low <= 1'b0;
    wb(1'b1, MODE_OFS, 32'h0);
    for (int i = 0; i < 4; i++) begin
      host.send(sbyte[i], (i == 0) ? 12 : 8);
      wb(1'b0, MODE_OFS, 32'h0);
      check(rd_q, smode[i]);
    end
    // Write without byte lane 0 leaves the mode alone
    wsel = 4'h2;
    wb(1'b1, MODE_OFS, 32'h0);
    wsel = 4'h1;
    wb(1'b0, MODE_OFS, 32'h0);
    check(rd_q, 32'h3);
    // shutdown and mute written before the supply drops
    wb(1'b1, MODE_OFS, 32'h0);
    low <= 1'b1;
    repeat (3) @(posedge mclk_i);
    check_drive(1'b0, 1'b0);
    wrap_up();
  end
endmodule
